// [core/trip_logic_fault_recorder.sv]
//Contract
//- Trip request is OR of factory, supervisory, front panel and binary input trips and user trip conditions.
//- Trip block input suppresses every trip aggregation output.
//- Trip relay contact follows general trip with no further gating.
//- User term ORs both stages of five voltage/frequency trips plus rate trip.
//- Trips accepted from protection blocks, supervisory, front panel, binary inputs.
//- Recorder operation off or on, off after reset; off means no recording.
//- Pre/post 100..1000 ms default 200; overall limit 500..10000 default 1000.
//- Four analog channels: three line voltages and fourth voltage input.
//- Binary channels: trip, protection start/trip flags, synchrocheck releases.
//
// Added by the designer: the plain strobed port and the address map.
`timescale 1ns/1ps
module trip_logic_fault_recorder
  import trip_rec_pkg::*;
#(
  parameter int MS_CYCLES = trip_rec_pkg::CYCLES_PER_MS,
  parameter int FACT_N    = 1
) (
  input  wire logic                             core_clk_i,
  input  wire logic                             rst_n_i,
  // Trip sources
  input  wire logic [FACT_N-1:0]                factory_trip_i,
  input  wire logic                             supervisory_trip_i,
  input  wire logic                             front_panel_trip_i,
  input  wire logic                             binary_input_trip_i,
  input  wire logic                             trip_block_in_i,
  input  wire logic [1:0]                       ov_start_i,
  input  wire logic [1:0]                       ov_trip_i,
  input  wire logic [1:0]                       uv_start_i,
  input  wire logic [1:0]                       uv_trip_i,
  input  wire logic [1:0]                       rov_start_i,
  input  wire logic [1:0]                       rov_trip_i,
  input  wire logic [1:0]                       of_start_i,
  input  wire logic [1:0]                       of_trip_i,
  input  wire logic [1:0]                       uf_start_i,
  input  wire logic [1:0]                       uf_trip_i,
  input  wire logic                             rocof_start_i,
  input  wire logic                             rocof_trip_i,
  input  wire logic                             sync_release_auto_i,
  input  wire logic                             sync_release_manual_i,
  // Analog samples
  input  wire logic                             sample_valid_i,
  input  wire logic [trip_rec_pkg::ANALOG_W-1:0] line1_voltage_i,
  input  wire logic [trip_rec_pkg::ANALOG_W-1:0] line2_voltage_i,
  input  wire logic [trip_rec_pkg::ANALOG_W-1:0] line3_voltage_i,
  input  wire logic [trip_rec_pkg::ANALOG_W-1:0] fourth_voltage_input_i,
  // Register port
  input  wire logic [7:0]                       reg_addr_i,
  input  wire logic [31:0]                      reg_wdata_i,
  input  wire logic                             reg_wr_i,
  input  wire logic                             reg_rd_i,
  output logic [31:0]                           reg_rdata_o,
  output logic                                  irq_o,
  // Trip outputs
  output logic                                  general_trip_out_o,
  output logic                                  trip_relay_o,
  // Record stream
  output logic                                  rec_valid_o,
  output logic                                  rec_post_o,
  output logic                                  rec_trigger_o,
  output logic                                  rec_done_o,
  output logic [trip_rec_pkg::TIME_W-1:0]       rec_pre_len_o,
  output logic [trip_rec_pkg::ANALOG_W-1:0]     rec_line1_o,
  output logic [trip_rec_pkg::ANALOG_W-1:0]     rec_line2_o,
  output logic [trip_rec_pkg::ANALOG_W-1:0]     rec_line3_o,
  output logic [trip_rec_pkg::ANALOG_W-1:0]     rec_fourth_o,
  output logic [trip_rec_pkg::BIN_CH_N-1:0]     rec_binary_o
);
  import trip_rec_pkg::*;

  // Refuse parameter values the logic cannot serve
  if (FACT_N < 1) begin : g_fact_chk
    $error("trip_logic_fault_recorder: FACT_N must be at least 1");
  end
  if (MS_CYCLES < 2) begin : g_ms_chk
    $error("trip_logic_fault_recorder: MS_CYCLES must be at least 2");
  end

  ////////////////////////////////////////////////////////////////////////////////
  // State
  typedef struct packed {
    logic                 oper;
    logic [TIME_W-1:0]    pre_time;
    logic [TIME_W-1:0]    post_time;
    logic [TIME_W-1:0]    max_time;
    logic [IRQ_W-1:0]     irq_stat;
    logic [IRQ_W-1:0]     irq_mask;
    rec_state_e           state;
    logic [TIME_W-1:0]    ms_cnt;
    logic [TIME_W-1:0]    pre_fill;
    logic [TIME_W-1:0]    post_lim;
    logic [TIME_W-1:0]    pre_len;
    logic                 trip_q;
    logic [15:0]          rec_count;
    logic [31:0]          rdata;
    logic                 valid;
    logic                 post;
    logic                 trigger;
    logic                 done;
    logic [ANALOG_W-1:0]  a1;
    logic [ANALOG_W-1:0]  a2;
    logic [ANALOG_W-1:0]  a3;
    logic [ANALOG_W-1:0]  a4;
    logic [BIN_CH_N-1:0]  bin;
  } core_s;

  core_s st_reg;
  core_s st_next;

  logic                ms_tick;
  logic                user_trip;
  logic                trip_request;
  logic                trip_rise;
  logic [BIN_CH_N-1:0] bin_now;
  logic [TIME_W-1:0]   pre_cap;
  logic [TIME_W-1:0]   room;

  ////////////////////////////////////////////////////////////////////////////////
  // Trip aggregation
  assign user_trip    = (|ov_trip_i) | (|uv_trip_i) | (|rov_trip_i)
                      | (|of_trip_i) | (|uf_trip_i) | rocof_trip_i;
  assign trip_request = (|factory_trip_i) | user_trip | supervisory_trip_i
                      | front_panel_trip_i | binary_input_trip_i;
  assign general_trip_out_o = trip_request & ~trip_block_in_i;
  assign trip_relay_o       = general_trip_out_o;
  assign trip_rise          = general_trip_out_o & ~st_reg.trip_q;

  // Binary channel vector
  assign bin_now = {sync_release_manual_i, sync_release_auto_i,
                    uv_trip_i[0], uv_start_i, rov_trip_i, rov_start_i,
                    ov_trip_i, ov_start_i, rocof_trip_i, rocof_start_i,
                    uf_trip_i, uf_start_i, of_trip_i, of_start_i,
                    general_trip_out_o};

  // Pre window kept below the overall limit
  assign pre_cap = (st_reg.pre_fill < st_reg.max_time) ? st_reg.pre_fill
                                                       : st_reg.max_time - 1'b1;
  assign room    = st_reg.max_time - pre_cap;

  ////////////////////////////////////////////////////////////////////////////////
  // Millisecond time base
  ms_tick_gen #(
    .CYCLES (MS_CYCLES)
  ) u_ms_tick (
    .core_clk_i (core_clk_i),
    .rst_n_i    (rst_n_i),
    .run_i      (st_reg.oper),
    .tick_o     (ms_tick)
  );

  // Clamp a written time into its legal range
  function automatic logic [TIME_W-1:0] clamp_time(input logic [31:0] v,
                                                   input logic [TIME_W-1:0] lo,
                                                   input logic [TIME_W-1:0] hi);
    logic [TIME_W-1:0] r;
    if (v < 32'(lo)) r = lo;
    else if (v > 32'(hi)) r = hi;
    else r = v[TIME_W-1:0];
    return r;
  endfunction : clamp_time

  ////////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    logic [IRQ_W-1:0] ev;
    ev          = '0;
    st_next     = st_reg;
    st_next.trigger = 1'b0;
    st_next.done    = 1'b0;
    st_next.valid   = 1'b0;
    st_next.rdata   = 32'h0000_0000;
    st_next.trip_q  = general_trip_out_o;

    // Register writes
    if (reg_wr_i) begin
      case (reg_addr_i)
        OFF_CTRL:      st_next.oper = reg_wdata_i[CTRL_OPER_BIT];
        OFF_PRE_TIME:  st_next.pre_time  = clamp_time(reg_wdata_i, WIN_TIME_MIN,
                                                      WIN_TIME_MAX);
        OFF_POST_TIME: st_next.post_time = clamp_time(reg_wdata_i, WIN_TIME_MIN,
                                                      WIN_TIME_MAX);
        OFF_MAX_TIME:  st_next.max_time  = clamp_time(reg_wdata_i, LIM_TIME_MIN,
                                                      LIM_TIME_MAX);
        OFF_IRQ_MASK:  st_next.irq_mask  = reg_wdata_i[IRQ_W-1:0];
        default: ;
      endcase
    end

    // Register reads, data stands one cycle later
    if (reg_rd_i) begin
      case (reg_addr_i)
        OFF_CTRL:       st_next.rdata[CTRL_OPER_BIT] = st_reg.oper;
        OFF_PRE_TIME:   st_next.rdata[TIME_W-1:0]    = st_reg.pre_time;
        OFF_POST_TIME:  st_next.rdata[TIME_W-1:0]    = st_reg.post_time;
        OFF_MAX_TIME:   st_next.rdata[TIME_W-1:0]    = st_reg.max_time;
        OFF_STATUS: begin
          st_next.rdata[STAT_CAPTURE_BIT] = (st_reg.state == REC_CAPTURE);
          st_next.rdata[STAT_TRIP_BIT]    = st_reg.trip_q;
          st_next.rdata[STAT_COUNT_LSB +: 16] = st_reg.rec_count;
        end
        OFF_IRQ_STATUS: st_next.rdata[IRQ_W-1:0] = st_reg.irq_stat;
        OFF_IRQ_MASK:   st_next.rdata[IRQ_W-1:0] = st_reg.irq_mask;
        default: ;
      endcase
    end

    // Sample capture while operating
    if (st_reg.oper && sample_valid_i) begin
      st_next.valid = 1'b1;
      st_next.a1    = line1_voltage_i;
      st_next.a2    = line2_voltage_i;
      st_next.a3    = line3_voltage_i;
      st_next.a4    = fourth_voltage_input_i;
      st_next.bin   = bin_now;
    end

    // Recorder sequence
    case (st_reg.state)
      REC_IDLE: begin
        st_next.post = 1'b0;
        if (!st_reg.oper) begin
          st_next.pre_fill = '0;
        end else if (trip_rise) begin
          st_next.state    = REC_CAPTURE;
          st_next.trigger  = 1'b1;
          st_next.post     = 1'b1;
          st_next.ms_cnt   = '0;
          st_next.pre_len  = pre_cap;
          st_next.post_lim = (st_reg.post_time < room) ? st_reg.post_time
                                                       : room;
          st_next.rec_count = st_reg.rec_count + 1'b1;
          ev[IRQ_TRIGGER_BIT] = 1'b1;
        end else if (ms_tick && st_reg.pre_fill < st_reg.pre_time) begin
          st_next.pre_fill = st_reg.pre_fill + 1'b1;
        end else if (st_reg.pre_fill > st_reg.pre_time) begin
          st_next.pre_fill = st_reg.pre_time;
        end
      end
      REC_CAPTURE: begin
        if (!st_reg.oper) begin
          st_next.state    = REC_IDLE;
          st_next.post     = 1'b0;
          st_next.done     = 1'b1;
          st_next.pre_fill = '0;
          ev[IRQ_DONE_BIT] = 1'b1;
        end else if (ms_tick) begin
          st_next.ms_cnt = st_reg.ms_cnt + 1'b1;
          if (st_reg.ms_cnt + 1'b1 >= st_reg.post_lim) begin
            st_next.state    = REC_IDLE;
            st_next.post     = 1'b0;
            st_next.done     = 1'b1;
            st_next.pre_fill = '0;
            ev[IRQ_DONE_BIT] = 1'b1;
          end
        end
      end
      default: begin
        st_next.state = REC_IDLE;
        st_next.post  = 1'b0;
      end
    endcase

    // Blocked trip request
    if (trip_request && trip_block_in_i && !st_reg.trip_q) begin
      ev[IRQ_BLOCKED_BIT] = 1'b1;
    end

    // Sticky status, set wins over write-one-clear
    if (reg_wr_i && reg_addr_i == OFF_IRQ_STATUS) begin
      st_next.irq_stat = (st_reg.irq_stat & ~reg_wdata_i[IRQ_W-1:0]) | ev;
    end else begin
      st_next.irq_stat = st_reg.irq_stat | ev;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      st_reg           <= '0;
      st_reg.oper      <= 1'b0;
      st_reg.pre_time  <= PRE_TIME_RST;
      st_reg.post_time <= POST_TIME_RST;
      st_reg.max_time  <= MAX_TIME_RST;
      st_reg.state     <= REC_IDLE;
    end else begin
      st_reg <= st_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign reg_rdata_o   = st_reg.rdata;
  assign irq_o         = |(st_reg.irq_stat & st_reg.irq_mask);
  assign rec_valid_o   = st_reg.valid;
  assign rec_post_o    = st_reg.post;
  assign rec_trigger_o = st_reg.trigger;
  assign rec_done_o    = st_reg.done;
  assign rec_pre_len_o = st_reg.pre_len;
  assign rec_line1_o   = st_reg.a1;
  assign rec_line2_o   = st_reg.a2;
  assign rec_line3_o   = st_reg.a3;
  assign rec_fourth_o  = st_reg.a4;
  assign rec_binary_o  = st_reg.bin;

endmodule : trip_logic_fault_recorder

// [core/trip_rec_pkg.sv]
package trip_rec_pkg;

  // Register byte offsets
  localparam logic [7:0] OFF_CTRL       = 8'h00;
  localparam logic [7:0] OFF_PRE_TIME   = 8'h04;
  localparam logic [7:0] OFF_POST_TIME  = 8'h08;
  localparam logic [7:0] OFF_MAX_TIME   = 8'h0C;
  localparam logic [7:0] OFF_STATUS     = 8'h10;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h14;
  localparam logic [7:0] OFF_IRQ_MASK   = 8'h18;

  // Field positions
  localparam int CTRL_OPER_BIT     = 0;
  localparam int STAT_CAPTURE_BIT  = 0;
  localparam int STAT_TRIP_BIT     = 1;
  localparam int STAT_COUNT_LSB    = 16;
  localparam int IRQ_TRIGGER_BIT   = 0;
  localparam int IRQ_DONE_BIT      = 1;
  localparam int IRQ_BLOCKED_BIT   = 2;
  localparam int IRQ_W             = 3;

  // Times in milliseconds
  localparam int TIME_W = 14;
  localparam logic [TIME_W-1:0] PRE_TIME_RST  = 14'd200;
  localparam logic [TIME_W-1:0] POST_TIME_RST = 14'd200;
  localparam logic [TIME_W-1:0] MAX_TIME_RST  = 14'd1000;
  localparam logic [TIME_W-1:0] WIN_TIME_MIN  = 14'd100;
  localparam logic [TIME_W-1:0] WIN_TIME_MAX  = 14'd1000;
  localparam logic [TIME_W-1:0] LIM_TIME_MIN  = 14'd500;
  localparam logic [TIME_W-1:0] LIM_TIME_MAX  = 14'd10000;

  // Millisecond tick derived from the clock period
  localparam int CLK_PERIOD_NS = 8;
  localparam int MS_IN_NS      = 1000000;
  localparam int CYCLES_PER_MS = MS_IN_NS / CLK_PERIOD_NS;

  // Channel layout
  localparam int ANALOG_W = 16;
  localparam int BIN_CH_N = 24;

  // Recorder states
  typedef enum logic [1:0] {
    REC_IDLE    = 2'b01,
    REC_CAPTURE = 2'b10
  } rec_state_e;

endpackage : trip_rec_pkg

// [core/ms_tick_gen.sv]
`timescale 1ns/1ps
module ms_tick_gen #(
  parameter int CYCLES = trip_rec_pkg::CYCLES_PER_MS
) (
  input  wire logic core_clk_i,
  input  wire logic rst_n_i,
  input  wire logic run_i,
  output logic      tick_o
);
  localparam int CNT_W = $clog2(CYCLES + 1);

  // Refuse a divider too short to give a one-cycle pulse
  if (CYCLES < 2) begin : g_cycles_chk
    $error("ms_tick_gen: CYCLES must be at least 2");
  end

  logic [CNT_W-1:0] cnt_reg;

  // Free divider, restarted while not running
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i || !run_i) begin
      cnt_reg <= '0;
      tick_o  <= 1'b0;
    end else if (cnt_reg == CNT_W'(CYCLES - 1)) begin
      cnt_reg <= '0;
      tick_o  <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + 1'b1;
      tick_o  <= 1'b0;
    end
  end
endmodule : ms_tick_gen

// [sim/trip_rec_chk.sv]
`timescale 1ns/1ps
module trip_rec_chk
  import trip_rec_pkg::*;
#(
  parameter int MS_CYCLES = 8,
  parameter int FACT_N    = 1
) (
  input wire logic                core_clk_i,
  input wire logic                rst_n_i,
  input wire logic [FACT_N-1:0]   factory_trip_i,
  input wire logic                supervisory_trip_i,
  input wire logic                front_panel_trip_i,
  input wire logic                binary_input_trip_i,
  input wire logic                trip_block_in_i,
  input wire logic [1:0]          ov_trip_i,
  input wire logic [1:0]          uv_trip_i,
  input wire logic [1:0]          rov_trip_i,
  input wire logic [1:0]          of_trip_i,
  input wire logic [1:0]          uf_trip_i,
  input wire logic                rocof_trip_i,
  input wire logic                rocof_start_i,
  input wire logic                sync_release_auto_i,
  input wire logic                sync_release_manual_i,
  input wire logic                sample_valid_i,
  input wire logic [ANALOG_W-1:0] line1_voltage_i,
  input wire logic [ANALOG_W-1:0] line2_voltage_i,
  input wire logic [ANALOG_W-1:0] line3_voltage_i,
  input wire logic [ANALOG_W-1:0] fourth_voltage_input_i,
  input wire logic [7:0]          reg_addr_i,
  input wire logic [31:0]         reg_wdata_i,
  input wire logic                reg_wr_i,
  input wire logic                general_trip_out_o,
  input wire logic                trip_relay_o,
  input wire logic                rec_valid_o,
  input wire logic                rec_post_o,
  input wire logic                rec_trigger_o,
  input wire logic                rec_done_o,
  input wire logic [ANALOG_W-1:0] rec_line1_o,
  input wire logic [ANALOG_W-1:0] rec_line2_o,
  input wire logic [ANALOG_W-1:0] rec_line3_o,
  input wire logic [ANALOG_W-1:0] rec_fourth_o,
  input wire logic [BIN_CH_N-1:0] rec_binary_o
);
  localparam int POST_CAP = 1000 * MS_CYCLES + 2;
  logic        oper_reg;
  logic [31:0] post_cnt_reg;
  // Mirror of the operation bit and length of the running capture
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      oper_reg     <= 1'h0;
      post_cnt_reg <= '0;
    end else begin
      if (reg_wr_i && reg_addr_i == OFF_CTRL)
        oper_reg <= reg_wdata_i[CTRL_OPER_BIT];
      post_cnt_reg <= rec_post_o ? post_cnt_reg + 32'h0000_0001 : '0;
    end
  end
  default clocking @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_n_i);
  ////////////////////////////////////////////////////////////////////////////////
  trip_or_a: assert property (
    general_trip_out_o == ((|factory_trip_i | supervisory_trip_i | front_panel_trip_i
      | binary_input_trip_i | |ov_trip_i | |uv_trip_i | |rov_trip_i | |of_trip_i
      | |uf_trip_i | rocof_trip_i) & !trip_block_in_i)) else $error("trip not source OR");
  block_a: assert property (trip_block_in_i |-> !general_trip_out_o)
    else $error("trip passed while blocked");
  relay_a: assert property (trip_relay_o == general_trip_out_o)
    else $error("relay differs from general trip");
  oper_on_a: assert property (sample_valid_i && oper_reg |=> rec_valid_o)
    else $error("sample not recorded");
  oper_off_a: assert property (rec_valid_o |-> $past(oper_reg && sample_valid_i))
    else $error("record without cause");
  analog_copy_a: assert property (rec_valid_o |->
    {rec_line1_o, rec_line2_o, rec_line3_o, rec_fourth_o} == $past({line1_voltage_i,
    line2_voltage_i, line3_voltage_i, fourth_voltage_input_i}))
    else $error("analog channel wrong");
  binary_copy_a: assert property (rec_valid_o |->
    rec_binary_o[0] == $past(general_trip_out_o) && rec_binary_o[4:3] == $past(of_trip_i)
    && rec_binary_o[10:9] == $past({rocof_trip_i, rocof_start_i})
    && rec_binary_o[23:21] == $past({sync_release_manual_i, sync_release_auto_i, uv_trip_i[0]}))
    else $error("binary channel wrong");
  trig_rise_a: assert property (rec_trigger_o |-> rec_post_o && !$past(rec_post_o)
    && $past(general_trip_out_o) && !$past(general_trip_out_o, 2)) else $error("bad trigger");
  done_end_a: assert property ($fell(rec_post_o) && $past(rst_n_i) |-> rec_done_o)
    else $error("capture ended without done");
  post_len_a: assert property (post_cnt_reg <= POST_CAP)
    else $error("capture too long");
  trig_c: cover property (rec_trigger_o);
  done_c: cover property (rec_done_o);
  blk_c: cover property (trip_block_in_i && supervisory_trip_i);
endmodule : trip_rec_chk
////////////////////////////////////////////////////////////////////////////////
bind trip_logic_fault_recorder trip_rec_chk #(.MS_CYCLES(MS_CYCLES), .FACT_N(FACT_N)) chk (
  .core_clk_i, .rst_n_i, .factory_trip_i, .supervisory_trip_i, .front_panel_trip_i,
  .binary_input_trip_i, .trip_block_in_i, .ov_trip_i, .uv_trip_i, .rov_trip_i, .of_trip_i,
  .uf_trip_i, .rocof_trip_i, .rocof_start_i, .sync_release_auto_i, .sync_release_manual_i,
  .sample_valid_i, .line1_voltage_i, .line2_voltage_i, .line3_voltage_i,
  .fourth_voltage_input_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .general_trip_out_o,
  .trip_relay_o, .rec_valid_o, .rec_post_o, .rec_trigger_o, .rec_done_o, .rec_line1_o,
  .rec_line2_o, .rec_line3_o, .rec_fourth_o, .rec_binary_o);

// [sim/prot_blocks_model.sv]
`timescale 1ns/1ps
module prot_blocks_model (
  input  wire logic        core_clk_i,
  input  wire logic        rst_n_i,
  input  wire logic [17:0] cmd_i,
  input  wire logic        relay_i,
  output logic      [17:0] flags_o,
  output logic             sample_valid_o,
  output logic      [63:0] volts_o,
  output logic      [15:0] relay_ops_o
);
  logic [2:0] div_reg;
  logic       relay_reg;
  // Flags follow commands a clock late; one sample in eight clocks; relay pickups counted
  always @(posedge core_clk_i) begin
    flags_o <= cmd_i;
    volts_o <= {$urandom, $urandom};
    if (!rst_n_i) begin
      div_reg        <= 3'h0;
      sample_valid_o <= 1'h0;
      relay_reg      <= 1'h0;
      relay_ops_o    <= 16'h0000;
    end else begin
      div_reg        <= div_reg + 3'h1;
      sample_valid_o <= div_reg == 3'h7;
      relay_reg      <= relay_i;
      if (relay_i && !relay_reg)
        relay_ops_o <= relay_ops_o + 16'h0001;
    end
  end
endmodule : prot_blocks_model

// [sim/trip_logic_fault_recorder_bench.sv]
`timescale 1ns/1ps
module trip_logic_fault_recorder_bench;
  import trip_rec_pkg::*;
  localparam int MS = 8;
  logic        core_clk_i = 1'h0;
  logic        rst_n_i    = 1'h0;
  logic [17:0] cmd        = '0;
  logic        blk        = 1'h0;
  logic [7:0]  addr       = '0;
  logic [31:0] wdata      = '0;
  logic        wr         = 1'h0;
  logic        rd         = 1'h0;
  logic        rd_pend    = 1'h0;
  logic [17:0] flags;
  logic        sv;
  logic [63:0] volts;
  logic [15:0] relay_ops;
  logic [31:0] rdata;
  logic [13:0] pre_len;
  logic        irq, gtrip, relay, post, trig, done;
  logic [31:0] rd_q[$], pre_q[$], len_q[$];
  logic [2:0]  lvl_q[$];
  int          num_errors   = 0;
  int          total_checks = 0;
  int          trig_cnt     = 0;
  int          cyc          = 0;
  int          exp_ms;
  always #4 core_clk_i = ~core_clk_i;
  ////////////////////////////////////////////////////////////////////////////////
  prot_blocks_model far (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .cmd_i(cmd),
    .relay_i(relay), .flags_o(flags), .sample_valid_o(sv), .volts_o(volts),
    .relay_ops_o(relay_ops));
  trip_logic_fault_recorder #(.MS_CYCLES(MS), .FACT_N(1)) dut (
    .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .factory_trip_i(flags[0]),
    .supervisory_trip_i(flags[1]), .front_panel_trip_i(flags[2]),
    .binary_input_trip_i(flags[3]), .trip_block_in_i(blk), .ov_start_i({2{flags[15]}}),
    .ov_trip_i(flags[5:4]), .uv_start_i({2{flags[15]}}), .uv_trip_i(flags[7:6]),
    .rov_start_i({2{flags[15]}}), .rov_trip_i(flags[9:8]), .of_start_i({2{flags[15]}}),
    .of_trip_i(flags[11:10]), .uf_start_i({2{flags[15]}}), .uf_trip_i(flags[13:12]),
    .rocof_start_i(flags[15]), .rocof_trip_i(flags[14]), .sync_release_auto_i(flags[16]),
    .sync_release_manual_i(flags[17]), .sample_valid_i(sv), .line1_voltage_i(volts[15:0]),
    .line2_voltage_i(volts[31:16]), .line3_voltage_i(volts[47:32]),
    .fourth_voltage_input_i(volts[63:48]), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .irq_o(irq),
    .general_trip_out_o(gtrip), .trip_relay_o(relay), .rec_valid_o(), .rec_post_o(post),
    .rec_trigger_o(trig), .rec_done_o(done), .rec_pre_len_o(pre_len), .rec_line1_o(),
    .rec_line2_o(), .rec_line3_o(), .rec_fourth_o(), .rec_binary_o());
  ////////////////////////////////////////////////////////////////////////////////
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    addr  <= a;
    wdata <= d;
    wr    <= 1'h1;
    @(posedge core_clk_i);
    wr    <= 1'h0;
  endtask : wreg
  task automatic rreg(input logic [7:0] a, input logic [31:0] e);
    @(posedge core_clk_i);
    addr <= a;
    rd   <= 1'h1;
    rd_q.push_back(e);
    @(posedge core_clk_i);
    rd   <= 1'h0;
  endtask : rreg
  task automatic look(input logic [2:0] e);
    @(posedge core_clk_i);
    lvl_q.push_back(e);
  endtask : look
  task automatic trip_case(input logic [17:0] c, input logic b);
    @(posedge core_clk_i);
    cmd <= c;
    // Block follows a clock later, in step with the model's delayed flags
    @(posedge core_clk_i);
    blk <= b;
    look({1'h0, {2{(|c[14:0]) & ~b}}});
  endtask : trip_case
  task automatic wait_done();
    for (int n = 0; n < 9000 && !done; n++)
      @(posedge core_clk_i);
  endtask : wait_done
  task automatic close_out();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : close_out
  ////////////////////////////////////////////////////////////////////////////////
  // Result watchers take the oldest note off each queue
  always @(posedge core_clk_i) begin
    rd_pend <= rd;
    if (rd_pend)
      cmp(rdata, rd_q.pop_front());
    if (trig) begin
      trig_cnt++;
      cyc = 0;
      cmp(32'(pre_len), pre_q.pop_front());
    end
    if (post)
      cyc++;
    if (done) begin
      exp_ms = len_q.pop_front();
      cmp((cyc >= (exp_ms - 1) * MS && cyc <= exp_ms * MS + 1) ? exp_ms : cyc, exp_ms);
    end
  end
  always @(negedge core_clk_i)
    if (lvl_q.size() > 0)
      cmp({29'h0, irq, relay, gtrip}, {29'h0, lvl_q.pop_front()});
  // Watchdog
  initial begin
    repeat (30000) @(posedge core_clk_i);
    num_errors++;
    close_out();
  end
  // Main sequence
  initial begin
    void'($urandom(68630));
    repeat (16) @(posedge core_clk_i);
    rst_n_i <= 1'h1;
    rreg(OFF_CTRL, 32'h0000_0000);
    rreg(OFF_PRE_TIME, 32'h0000_00C8);
    rreg(OFF_POST_TIME, 32'h0000_00C8);
    rreg(OFF_MAX_TIME, 32'h0000_03E8);
    wreg(OFF_POST_TIME, 32'h0000_0032);
    rreg(OFF_POST_TIME, 32'h0000_0064);
    wreg(OFF_MAX_TIME, 32'h0000_4E20);
    rreg(OFF_MAX_TIME, 32'h0000_2710);
    wreg(8'h1C, 32'hFFFF_FFFF);
    rreg(8'h1C, 32'h0000_0000);
    for (int i = 0; i < 18; i++) begin
      trip_case(18'(1 << i), 1'h0);
      trip_case(18'(1 << i), 1'h1);
      trip_case('0, 1'h0);
    end
    cmp(relay_ops, 32'h0000_000F);
    repeat (20) trip_case(18'($urandom), 1'($urandom));
    trip_case('0, 1'h0);
    cmp(trig_cnt, 0);
    wreg(OFF_PRE_TIME, 32'h0000_0064);
    wreg(OFF_POST_TIME, 32'h0000_0064);
    wreg(OFF_MAX_TIME, 32'h0000_01F4);
    wreg(OFF_CTRL, 32'h0000_0001);
    repeat (300) trip_case(18'($urandom) & 18'h3_8000, 1'h0);
    pre_q.push_back(32'h0000_0064);
    len_q.push_back(32'h0000_0064);
    trip_case(18'h0_0010, 1'h0);
    repeat (100) @(posedge core_clk_i);
    trip_case('0, 1'h0);
    trip_case(18'h0_0010, 1'h0);
    wait_done();
    trip_case('0, 1'h0);
    cmp(trig_cnt, 1);
    wreg(OFF_PRE_TIME, 32'h0000_03E8);
    wreg(OFF_POST_TIME, 32'h0000_03E8);
    repeat (4800) @(posedge core_clk_i);
    pre_q.push_back(32'h0000_01F3);
    len_q.push_back(32'h0000_0001);
    trip_case(18'h0_4000, 1'h0);
    wait_done();
    trip_case('0, 1'h0);
    cmp(trig_cnt, 2);
    rreg(OFF_IRQ_STATUS, 32'h0000_0007);
    wreg(OFF_IRQ_MASK, 32'h0000_0002);
    look(3'h4);
    wreg(OFF_IRQ_STATUS, 32'h0000_0002);
    look(3'h0);
    wreg(OFF_IRQ_STATUS, 32'h0000_0005);
    rreg(OFF_IRQ_STATUS, 32'h0000_0000);
    repeat (4) @(posedge core_clk_i);
    cmp(32'(rd_q.size() + pre_q.size() + len_q.size() + lvl_q.size()), 32'h0000_0000);
    close_out();
  end
endmodule : trip_logic_fault_recorder_bench
